// ==== design/serial_port_pkg.sv ====
// Purpose: Shared constants and types for the serial port baud and stop-collision block
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in the low byte lane
// Notes: Offsets are byte addresses, one aligned word per register
package serial_port_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_RELOAD = 8'h00;
    localparam logic [7:0] OFF_BUFFER = 8'h04;
    localparam logic [7:0] OFF_CTRL1 = 8'h08;
    localparam logic [7:0] OFF_CTRL2 = 8'h0C;
    localparam logic [7:0] OFF_CTRL3 = 8'h10;
    localparam logic [7:0] OFF_ADDR_MASK = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_IRQ_STS = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MSK = 8'h20;
    // Field positions
    localparam int CTRL1_WCOL = 7;
    localparam int CTRL1_EN = 5;
    localparam int CTRL1_CKP = 4;
    localparam int CTRL2_STOP_REQ = 2;
    localparam int STAT_SAMPLE_SEL = 7;
    localparam int STAT_EDGE_SEL = 6;
    localparam int STAT_STOP_SEEN = 4;
    localparam int STAT_BUF_FULL = 0;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_COLL = 1;
    // Mode codes in the low nibble of control one
    localparam logic [3:0] MODE_I2C_MASTER = 4'h8;
    localparam logic [3:0] MODE_SPI_MASTER_BRG = 4'hA;
    // Reset values and write masks
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [7:0] CTRL2_WMASK = 8'hBF;
    localparam logic [7:0] STATUS_WMASK = 8'hC0;
    // Timing: last prescaler count before each baud counter decrement, last serial edge index
    localparam logic PRESCALE_LAST = 1'b1;
    localparam logic [3:0] SPI_LAST_EDGE = 4'hF;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SDA_LOW = 5'b00010,
        ST_SCL_REL = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_SDA_REL = 5'b10000
    } stop_state_t;
endpackage

// ==== design/serial_port_brg.sv ====
// Purpose: Shared baud counter for I2C/SPI master clocks, Stop sequence with bus-collision detection
// Assumes: clk_i at 250 MHz, open-drain SDA/SCL resolved outside, pins asynchronous
// Notes: Only the baud-counter SPI master mode and the I2C Stop sequence are sequenced here
`timescale 1ns/10ps
module serial_port_brg (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sck_o,
    output logic sdo_o,
    input wire logic sdi_i,
    output logic slew_limit_o,
    output logic smbus_thresh_o,
    output logic irq_o
);
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == serial_port_pkg::OFF_RELOAD) || (a == serial_port_pkg::OFF_BUFFER) ||
               (a == serial_port_pkg::OFF_CTRL1) || (a == serial_port_pkg::OFF_CTRL2) ||
               (a == serial_port_pkg::OFF_CTRL3) || (a == serial_port_pkg::OFF_ADDR_MASK) ||
               (a == serial_port_pkg::OFF_STATUS) || (a == serial_port_pkg::OFF_IRQ_STS) ||
               (a == serial_port_pkg::OFF_IRQ_MSK);
    endfunction

    logic [7:0] aw_addr_ff, ar_addr_ff;
    logic [7:0] w_data_ff;
    logic w_lane_ff, have_aw_ff, have_w_ff, bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] reload_ff, tx_buf_ff, rx_buf_ff, ctrl1_ff, ctrl2_ff, ctrl3_ff, addr_mask_ff;
    logic wcol_ff, stop_req_ff, stop_seen_ff, buf_full_ff, sample_sel_ff, edge_sel_ff;
    logic [1:0] irq_sts_ff, irq_msk_ff;
    logic [7:0] bc_ff;
    logic pre_ff;
    logic sda_m_ff, sda_s_ff, scl_m_ff, scl_s_ff, sdi_m_ff, sdi_s_ff;
    serial_port_pkg::stop_state_t st_ff, nxt_st;
    logic spi_busy_ff, sck_ff, sdo_ff;
    logic [3:0] edge_ff;
    logic [7:0] tx_sh_ff, rx_sh_ff;
    logic wr_en, rd_en;
    logic [7:0] rd_val;
    logic port_on, i2c_master, spi_master, stop_active;
    logic buf_wr, spi_start, brg_load, brg_run, tick, rollover;
    logic coll, stop_ok, chg_edge, smp_edge;
    logic [7:0] nxt_rx;

    // Bus handshakes; readies drop while frozen so no item is taken unseen
    assign s_axi_awready_o = ce_i && !have_aw_ff && !bvalid_ff;
    assign s_axi_wready_o = ce_i && !have_w_ff && !bvalid_ff;
    assign s_axi_arready_o = ce_i && !rvalid_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign wr_en = ce_i && have_aw_ff && have_w_ff && !bvalid_ff;
    assign rd_en = s_axi_arready_o && s_axi_arvalid_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            have_aw_ff <= 1'b0;
            have_w_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 8'h00;
            w_lane_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= serial_port_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awready_o && s_axi_awvalid_i) begin
                have_aw_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr_i;
            end
            if (s_axi_wready_o && s_axi_wvalid_i) begin
                have_w_ff <= 1'b1;
                w_data_ff <= s_axi_wdata_i[7:0];
                w_lane_ff <= s_axi_wstrb_i[0];
            end
            if (wr_en) begin
                have_aw_ff <= 1'b0;
                have_w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= is_mapped(aw_addr_ff) ? serial_port_pkg::RESP_OKAY : serial_port_pkg::RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready_i) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        case (ar_addr_ff)
            serial_port_pkg::OFF_RELOAD: rd_val = reload_ff;
            serial_port_pkg::OFF_BUFFER: rd_val = rx_buf_ff;
            serial_port_pkg::OFF_CTRL1: rd_val = {wcol_ff, ctrl1_ff[6:0]};
            serial_port_pkg::OFF_CTRL2: rd_val = {ctrl2_ff[7:3], stop_req_ff, ctrl2_ff[1:0]};
            serial_port_pkg::OFF_CTRL3: rd_val = ctrl3_ff;
            serial_port_pkg::OFF_ADDR_MASK: rd_val = addr_mask_ff;
            serial_port_pkg::OFF_STATUS: rd_val = {sample_sel_ff, edge_sel_ff, 1'b0, stop_seen_ff, 3'b000, buf_full_ff};
            serial_port_pkg::OFF_IRQ_STS: rd_val = {6'h00, irq_sts_ff};
            serial_port_pkg::OFF_IRQ_MSK: rd_val = {6'h00, irq_msk_ff};
            default: rd_val = 8'h00;
        endcase
    end

    // Read data is captured one cycle after the address so the mux sees a registered address
    logic rd_pend_ff;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ar_addr_ff <= 8'h00;
            rd_pend_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= serial_port_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (rd_en) begin
                ar_addr_ff <= s_axi_araddr_i;
                rd_pend_ff <= 1'b1;
                rvalid_ff <= 1'b1;
                rdata_ff <= 32'h0000_0000;
            end else if (rd_pend_ff) begin
                rd_pend_ff <= 1'b0;
                rdata_ff <= {24'h00_0000, rd_val};
                rresp_ff <= is_mapped(ar_addr_ff) ? serial_port_pkg::RESP_OKAY : serial_port_pkg::RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready_i) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // rvalid rises with the address capture, one cycle before rdata is loaded
    logic rd_buf_hit;
    assign rd_buf_hit = ce_i && rd_pend_ff && (ar_addr_ff == serial_port_pkg::OFF_BUFFER);

    assign port_on = ctrl1_ff[serial_port_pkg::CTRL1_EN];
    assign i2c_master = port_on && (ctrl1_ff[3:0] == serial_port_pkg::MODE_I2C_MASTER);
    assign spi_master = port_on && (ctrl1_ff[3:0] == serial_port_pkg::MODE_SPI_MASTER_BRG);
    assign stop_active = (st_ff != serial_port_pkg::ST_IDLE);
    assign buf_wr = wr_en && w_lane_ff && (aw_addr_ff == serial_port_pkg::OFF_BUFFER);
    assign spi_start = buf_wr && spi_master && !spi_busy_ff;
    assign slew_limit_o = i2c_master && !sample_sel_ff;
    assign smbus_thresh_o = i2c_master && edge_sel_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reload_ff <= serial_port_pkg::REG_RST;
            tx_buf_ff <= serial_port_pkg::REG_RST;
            ctrl1_ff <= serial_port_pkg::REG_RST;
            ctrl2_ff <= serial_port_pkg::REG_RST;
            ctrl3_ff <= serial_port_pkg::REG_RST;
            addr_mask_ff <= serial_port_pkg::REG_RST;
            sample_sel_ff <= 1'b0;
            edge_sel_ff <= 1'b0;
            irq_msk_ff <= serial_port_pkg::IRQ_RST;
        end else if (wr_en && w_lane_ff) begin
            case (aw_addr_ff)
                serial_port_pkg::OFF_RELOAD: reload_ff <= w_data_ff;
                serial_port_pkg::OFF_CTRL1: ctrl1_ff <= w_data_ff;
                serial_port_pkg::OFF_CTRL2: ctrl2_ff <= w_data_ff & serial_port_pkg::CTRL2_WMASK;
                serial_port_pkg::OFF_CTRL3: ctrl3_ff <= w_data_ff;
                serial_port_pkg::OFF_ADDR_MASK: addr_mask_ff <= w_data_ff;
                serial_port_pkg::OFF_STATUS: begin
                    sample_sel_ff <= w_data_ff[serial_port_pkg::STAT_SAMPLE_SEL];
                    edge_sel_ff <= w_data_ff[serial_port_pkg::STAT_EDGE_SEL];
                end
                serial_port_pkg::OFF_IRQ_MSK: irq_msk_ff <= w_data_ff[1:0];
                serial_port_pkg::OFF_BUFFER: begin
                    if (!stop_active && !spi_busy_ff) begin
                        tx_buf_ff <= w_data_ff;
                    end
                end
                default: ;
            endcase
        end
    end

    // Write collision: set by a buffer write during Stop or a busy shift; software writes 0 to clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wcol_ff <= 1'b0;
        end else if (ce_i) begin
            if (buf_wr && (stop_active || spi_busy_ff)) begin
                wcol_ff <= 1'b1;
            end else if (wr_en && w_lane_ff && aw_addr_ff == serial_port_pkg::OFF_CTRL1 &&
                         !w_data_ff[serial_port_pkg::CTRL1_WCOL]) begin
                wcol_ff <= 1'b0;
            end
        end
    end

    // pins pass two flip-flops; only the second stage is ever compared
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sda_m_ff <= 1'b1;
            sda_s_ff <= 1'b1;
            scl_m_ff <= 1'b1;
            scl_s_ff <= 1'b1;
            sdi_m_ff <= 1'b0;
            sdi_s_ff <= 1'b0;
        end else if (ce_i) begin
            sda_m_ff <= sda_i;
            sda_s_ff <= sda_m_ff;
            scl_m_ff <= scl_i;
            scl_s_ff <= scl_m_ff;
            sdi_m_ff <= sdi_i;
            sdi_s_ff <= sdi_m_ff;
        end
    end

    // Shared baud counter: one decrement every second clock, so a rollover spans 2*(reload+1)
    // clocks and two rollovers make one serial period of clk/(4*(reload+1))
    assign tick = pre_ff == serial_port_pkg::PRESCALE_LAST;
    assign brg_run = spi_busy_ff || (st_ff == serial_port_pkg::ST_HOLD) || (st_ff == serial_port_pkg::ST_SDA_REL);
    assign rollover = ce_i && brg_run && tick && (bc_ff == 8'h00) && !brg_load;
    assign brg_load = ce_i && (spi_start || (st_ff == serial_port_pkg::ST_SCL_REL && scl_s_ff));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bc_ff <= 8'h00;
            pre_ff <= 1'b0;
        end else if (ce_i) begin
            if (brg_load) begin
                bc_ff <= reload_ff;
                pre_ff <= 1'b0;
            end else if (brg_run) begin
                pre_ff <= ~pre_ff;
                if (tick) begin
                    bc_ff <= (bc_ff == 8'h00) ? reload_ff : bc_ff - 8'h01;
                end
            end
        end
    end

    // Stop sequence
    assign coll = ((st_ff == serial_port_pkg::ST_HOLD) && !scl_s_ff) ||
                  ((st_ff == serial_port_pkg::ST_SDA_REL) && !scl_s_ff && !sda_s_ff) ||
                  ((st_ff == serial_port_pkg::ST_SDA_REL) && rollover && !sda_s_ff);
    assign stop_ok = (st_ff == serial_port_pkg::ST_SDA_REL) && rollover && sda_s_ff && scl_s_ff;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            serial_port_pkg::ST_IDLE: if (i2c_master && stop_req_ff) nxt_st = serial_port_pkg::ST_SDA_LOW;
            serial_port_pkg::ST_SDA_LOW: if (!sda_s_ff) nxt_st = serial_port_pkg::ST_SCL_REL;
            serial_port_pkg::ST_SCL_REL: if (scl_s_ff) nxt_st = serial_port_pkg::ST_HOLD;
            serial_port_pkg::ST_HOLD: if (rollover) nxt_st = serial_port_pkg::ST_SDA_REL;
            serial_port_pkg::ST_SDA_REL: if (rollover) nxt_st = serial_port_pkg::ST_IDLE;
            default: nxt_st = serial_port_pkg::ST_IDLE;
        endcase
        if (coll || !i2c_master) begin
            nxt_st = serial_port_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_ff <= serial_port_pkg::ST_IDLE;
        end else if (ce_i) begin
            st_ff <= nxt_st;
        end
    end

    // Stop request: software sets, hardware clears on finish or collision; a set in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stop_req_ff <= 1'b0;
            stop_seen_ff <= 1'b0;
        end else if (ce_i) begin
            if (wr_en && w_lane_ff && aw_addr_ff == serial_port_pkg::OFF_CTRL2 &&
                w_data_ff[serial_port_pkg::CTRL2_STOP_REQ]) begin
                stop_req_ff <= 1'b1;
            end else if (coll || stop_ok) begin
                stop_req_ff <= 1'b0;
            end
            if (!port_on) begin
                stop_seen_ff <= 1'b0;
            end else if (stop_ok) begin
                stop_seen_ff <= 1'b1;
            end
        end
    end

    // Open-drain lines only ever pull low; idle and abort leave both released
    assign sda_o = 1'b0;
    assign scl_o = 1'b0;
    assign sda_oe_o = (st_ff == serial_port_pkg::ST_SDA_LOW) || (st_ff == serial_port_pkg::ST_SCL_REL) ||
                      (st_ff == serial_port_pkg::ST_HOLD);
    assign scl_oe_o = (st_ff == serial_port_pkg::ST_SDA_LOW);

    // SPI master shift on baud rollovers; edge_ff counts serial edges 0..15
    assign chg_edge = edge_sel_ff ? edge_ff[0] : (!edge_ff[0] && edge_ff != 4'h0);
    assign smp_edge = sample_sel_ff ? (chg_edge || (edge_ff == serial_port_pkg::SPI_LAST_EDGE && !edge_sel_ff))
                                    : (edge_ff[0] != edge_sel_ff);
    assign nxt_rx = smp_edge ? {rx_sh_ff[6:0], sdi_s_ff} : rx_sh_ff;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            spi_busy_ff <= 1'b0;
            sck_ff <= 1'b0;
            sdo_ff <= 1'b0;
            edge_ff <= 4'h0;
            tx_sh_ff <= 8'h00;
            rx_sh_ff <= 8'h00;
        end else if (ce_i) begin
            if (spi_start) begin
                spi_busy_ff <= 1'b1;
                sck_ff <= ctrl1_ff[serial_port_pkg::CTRL1_CKP];
                sdo_ff <= w_data_ff[7];
                tx_sh_ff <= w_data_ff;
                edge_ff <= 4'h0;
            end else if (spi_busy_ff && rollover) begin
                sck_ff <= ~sck_ff;
                rx_sh_ff <= nxt_rx;
                edge_ff <= edge_ff + 4'h1;
                if (chg_edge) begin
                    tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                    sdo_ff <= tx_sh_ff[6];
                end
                if (edge_ff == serial_port_pkg::SPI_LAST_EDGE) begin
                    spi_busy_ff <= 1'b0;
                end
            end
        end
    end
    assign sck_o = sck_ff;
    assign sdo_o = sdo_ff;

    logic spi_done;
    assign spi_done = spi_busy_ff && rollover && (edge_ff == serial_port_pkg::SPI_LAST_EDGE);

    // Receive buffer; full flag set by a finished byte wins over a read that clears it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_buf_ff <= 8'h00;
            buf_full_ff <= 1'b0;
        end else if (ce_i) begin
            if (spi_done) begin
                rx_buf_ff <= nxt_rx;
                buf_full_ff <= 1'b1;
            end else if (rd_buf_hit) begin
                buf_full_ff <= 1'b0;
            end
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_sts_ff <= serial_port_pkg::IRQ_RST;
        end else if (ce_i) begin
            irq_sts_ff[serial_port_pkg::IRQ_DONE] <= (spi_done || stop_ok) ||
                (irq_sts_ff[serial_port_pkg::IRQ_DONE] && !(wr_en && w_lane_ff &&
                 aw_addr_ff == serial_port_pkg::OFF_IRQ_STS && w_data_ff[serial_port_pkg::IRQ_DONE]));
            irq_sts_ff[serial_port_pkg::IRQ_COLL] <= coll ||
                (irq_sts_ff[serial_port_pkg::IRQ_COLL] && !(wr_en && w_lane_ff &&
                 aw_addr_ff == serial_port_pkg::OFF_IRQ_STS && w_data_ff[serial_port_pkg::IRQ_COLL]));
        end
    end
    assign irq_o = |(irq_sts_ff & irq_msk_ff);

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_stop_sda_first: assert property ((st_ff == serial_port_pkg::ST_SDA_LOW) |-> sda_oe_o && scl_oe_o)
        else $error("Stop did not hold both lines low at start");
    chk_stop_load: assert property (ce_i && st_ff == serial_port_pkg::ST_SCL_REL && scl_s_ff |=>
        (bc_ff == $past(reload_ff)) && (st_ff == serial_port_pkg::ST_HOLD))
        else $error("Baud counter not loaded when SCL rose");
    chk_case1_coll: assert property (ce_i && st_ff == serial_port_pkg::ST_SDA_REL && rollover && !sda_s_ff |=>
        irq_sts_ff[serial_port_pkg::IRQ_COLL] && st_ff == serial_port_pkg::ST_IDLE && !sda_oe_o)
        else $error("Low SDA after count not taken as collision");
    chk_case2_coll: assert property (ce_i && st_ff == serial_port_pkg::ST_HOLD && !scl_s_ff |=>
        irq_sts_ff[serial_port_pkg::IRQ_COLL] && !stop_req_ff && !scl_oe_o)
        else $error("Early SCL low not taken as collision");
    chk_brg_count: assert property (ce_i && brg_run && tick && bc_ff != 8'h00 && !brg_load |=>
        bc_ff == $past(bc_ff) - 8'h01)
        else $error("Baud counter did not count down");
    chk_brg_frozen: assert property (ce_i && !brg_run && !brg_load |=> $stable(bc_ff) && $stable(sck_ff))
        else $error("Counter or clock moved while idle");
    chk_brg_reload: assert property (rollover |=> bc_ff == $past(reload_ff))
        else $error("Rollover did not reload the counter");
    chk_spi_sck_toggle: assert property (spi_busy_ff && rollover && !spi_start |=> sck_ff != $past(sck_ff))
        else $error("Serial clock did not toggle on rollover");
    chk_coll_irq: assert property (ce_i && coll |=> irq_sts_ff[serial_port_pkg::IRQ_COLL] ##0
        (irq_msk_ff[serial_port_pkg::IRQ_COLL] -> irq_o))
        else $error("Collision did not raise its flag");
endmodule // serial_port_brg

// ==== sim/i2c_spi_peer.sv ====
// Purpose: Far-side model: open-drain I2C lines with pull-ups, SPI loopback slave
// Assumes: A forced low stands for another master driving a zero
// Notes: Loopback keeps the expected SPI byte equal to the byte sent
`timescale 1ns/10ps
module i2c_spi_peer (
    input wire logic sda_oe_i,
    input wire logic scl_oe_i,
    input wire logic sda_low_i,
    input wire logic scl_low_i,
    input wire logic sdo_i,
    output logic sda_o,
    output logic scl_o,
    output logic sdi_o
);
    assign sda_o = !(sda_oe_i || sda_low_i);
    assign scl_o = !(scl_oe_i || scl_low_i);
    assign sdi_o = sdo_i;
endmodule // i2c_spi_peer

// ==== sim/serial_port_brg_tb_top.sv ====
// Purpose: Self-checking bench for the baud counter and Stop collision logic
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes: Reload kept at 3, so one rollover is 8 clocks
`timescale 1ns/10ps
module serial_port_brg_tb_top;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
    logic clk_i = 0, rst_n_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, sdal = 0, scll = 0, s, ce = 1;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd_d;
    logic [1:0] rd_r, br;
    wire logic awr, wrr, bv, arr, rv, sda, scl, sdao, sdaoe, sclo, scloe, sck, sdo, sdi, slew, smb, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int bad_count = 0, num_checks = 0, cyc = 0, n;
    row_t rows[4] = '{'{8'h00, 32'h0000_0003, 32'h0000_0003, 2'b00}, '{8'h18, 32'h0000_00FF, 32'h0000_00C0, 2'b00},
        '{8'h20, 32'h0000_0003, 32'h0000_0003, 2'b00}, '{8'h40, 32'h0000_0001, 32'h0000_0000, 2'b10}};
    serial_port_brg dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
        .sda_i(sda), .sda_o(sdao), .sda_oe_o(sdaoe), .scl_i(scl), .scl_o(sclo), .scl_oe_o(scloe),
        .sck_o(sck), .sdo_o(sdo), .sdi_i(sdi), .slew_limit_o(slew), .smbus_thresh_o(smb), .irq_o(irq));
    i2c_spi_peer peer_u (.sda_oe_i(sdaoe), .scl_oe_i(scloe), .sda_low_i(sdal), .scl_low_i(scll),
        .sdo_i(sdo), .sda_o(sda), .scl_o(scl), .sdi_o(sdi));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        do begin
            @(posedge clk_i);
            if (awr === 1'b1) awv <= 0;
            if (wrr === 1'b1) wv <= 0;
        end while (bv !== 1'b1);
        br = bresp; bry <= 0;
        @(posedge clk_i);
    endtask
    task rd(input logic [7:0] a);
        ara <= a; arv <= 1;
        do @(posedge clk_i); while (arr !== 1'b1);
        arv <= 0;
        repeat (2) @(posedge clk_i);
        rry <= 1;
        do @(posedge clk_i); while (rv !== 1'b1);
        rd_d = rdata; rd_r = rresp; rry <= 0;
        @(posedge clk_i);
    endtask
    task wait_irq;
        while (irq !== 1'b1) @(posedge clk_i);
    endtask
    task end_of_test;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1;
        @(posedge clk_i);
        rd(8'h18); chk(rd_d, 32'h0000_0000);
        chk(irq, 1'b0);
        // Reload 3 only: values 0..2 are unsupported in I2C; SPI used as master only
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d); chk(br, rows[i].r);
            rd(rows[i].a); chk(rd_d, rows[i].e); chk(rd_r, rows[i].r);
        end
        $display("register rows done");
        wr(8'h08, 32'h0000_0028); chk(slew, 1'b0); chk(smb, 1'b1);
        wr(8'h18, 32'h0000_0000); chk(slew, 1'b1); chk(smb, 1'b0);
        wr(8'h08, 32'h0000_002A); wr(8'h04, 32'h0000_00A5);
        s = sck; while (sck === s) @(posedge clk_i);
        s = sck; n = 0;
        while (sck === s) begin @(posedge clk_i); n++; end
        chk(n, 8);
        // Freeze mid-transfer: the serial clock must not move while the enable is low
        ce <= 0; s = sck; repeat (24) @(posedge clk_i);
        chk(sck, s);
        ce <= 1;
        wait_irq(); rd(8'h04); chk(rd_d, 32'h0000_00A5);
        s = sck; repeat (40) @(posedge clk_i);
        chk(sck, s);
        wr(8'h1C, 32'h0000_0003); chk(irq, 1'b0);
        $display("spi transfer done");
        wr(8'h08, 32'h0000_0028); wr(8'h0C, 32'h0000_0004);
        wait_irq(); rd(8'h18); chk(rd_d[4], 1'b1);
        chk({sdao, sclo}, 2'b00);
        rd(8'h1C); chk(rd_d, 32'h0000_0001); wr(8'h1C, 32'h0000_0003);
        sdal <= 1; wr(8'h0C, 32'h0000_0004);
        wait_irq(); rd(8'h1C); chk(rd_d, 32'h0000_0002);
        rd(8'h0C); chk(rd_d[2], 1'b0); chk({sdaoe, scloe}, 2'b00);
        sdal <= 0; wr(8'h1C, 32'h0000_0003);
        $display("stop case one done");
        wr(8'h0C, 32'h0000_0004);
        while (scloe !== 1'b0) @(posedge clk_i);
        repeat (5) @(posedge clk_i);
        scll <= 1;
        wait_irq(); rd(8'h1C); chk(rd_d, 32'h0000_0002);
        rd(8'h0C); chk(rd_d[2], 1'b0); chk({sdaoe, scloe}, 2'b00);
        scll <= 0; rst_n_i <= 0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1; rd(8'h00); chk(rd_d, 32'h0000_0000);
        $display("stop case two and reset done");
        end_of_test();
    end
endmodule // serial_port_brg_tb_top
